// ---- rtl/fpe_pkg.sv ----
// constants and types shared by the nvm program, erase and protect block
`default_nettype none
package fpe_pkg;
  // ==========================================================================
  // array geometry
  localparam int unsigned    ARR_AW       = 16;
  localparam int unsigned    PAGE_BITS    = 9;
  localparam int unsigned    ROW_BITS     = 6;
  localparam logic [15:0]    MEM_TOP      = 16'hFFFF;
  localparam logic [15:0]    KEEP_LO      = 16'hFFCF;
  localparam logic [15:0]    CLK_OPT_ADDR = 16'hFFCF;
  localparam logic [7:0]     ERASED_BYTE  = 8'hFF;
  localparam int unsigned    OSC_HI_BIT   = 7;
  localparam int unsigned    OSC_LO_BIT   = 6;
  // ==========================================================================
  // apb map
  localparam int unsigned    PADDR_W      = 19;
  localparam int unsigned    ARRAY_SEL    = 18;
  localparam logic [15:0]    IDX_CONTROL  = 16'hFE08;
  localparam logic [15:0]    IDX_PROTECT  = 16'hFE09;
  localparam logic [15:0]    IDX_STATUS   = 16'hFE0A;
  localparam logic [18:0]    ADDR_CONTROL = {1'b0, IDX_CONTROL, 2'b00};
  localparam logic [18:0]    ADDR_PROTECT = {1'b0, IDX_PROTECT, 2'b00};
  localparam logic [18:0]    ADDR_STATUS  = {1'b0, IDX_STATUS, 2'b00};
  // ==========================================================================
  // register fields and reset values
  localparam int unsigned    ST_TARGET    = 0;
  localparam int unsigned    ST_BUSY      = 1;
  localparam int unsigned    ST_REFUSED   = 2;
  localparam logic [7:0]     PROT_RESET   = 8'h00;
  localparam logic [7:0]     PROT_NONE    = 8'hFF;
  localparam logic [7:0]     PROT_ALL_MAX = 8'h09;
  localparam logic [7:0]     PROT_TOP_MIN = 8'hFC;
  typedef struct packed {
    logic high_voltage_enable;
    logic mass;
    logic erase;
    logic program_select;
  } fpe_ctl_t;
  localparam fpe_ctl_t       CTL_RESET    = '{1'b0, 1'b0, 1'b0, 1'b0};
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_PAGE = 2'b01,
    SW_MASS = 2'b10
  } fpe_sweep_t;
endpackage : fpe_pkg
`default_nettype wire

// ---- rtl/fpe_arr_if.sv ----
// signals between the sequencer and the memory array
`default_nettype none
interface fpe_arr_if;
  logic [15:0] rd_addr;
  logic [7:0]  rd_data;
  logic        prog_stb;
  logic [15:0] prog_addr;
  logic [7:0]  prog_data;
  logic        erase_stb;
  logic        erase_mass;
  logic [6:0]  erase_page;
  logic        busy;
  logic [1:0]  clock_opt;
  modport ctl (output rd_addr, prog_stb, prog_addr, prog_data, erase_stb, erase_mass,
               erase_page, input rd_data, busy, clock_opt);
  modport arr (input rd_addr, prog_stb, prog_addr, prog_data, erase_stb, erase_mass,
               erase_page, output rd_data, busy, clock_opt);
endinterface : fpe_arr_if
`default_nettype wire

// ---- rtl/fpe_prot.sv ----
// protected range decode for one address
`default_nettype none
module fpe_prot (
  // protect register and address
  input  wire logic [7:0]  protect_start_bits,
  input  wire logic [15:0] addr,
  // decode
  output logic [15:0] start,
  output logic        hit
);
  // ==========================================================================
  // start address
  always_comb begin
    if (protect_start_bits <= fpe_pkg::PROT_ALL_MAX) begin
      start = '0;
    end else if (protect_start_bits >= fpe_pkg::PROT_TOP_MIN) begin
      start = fpe_pkg::KEEP_LO;
    end else begin
      start = {protect_start_bits[7:1], 9'h000};
    end
  end
  assign hit = (addr >= fpe_pkg::KEEP_LO) ||
               ((protect_start_bits != fpe_pkg::PROT_NONE) && (addr >= start) &&
                (addr <= fpe_pkg::MEM_TOP));
endmodule : fpe_prot
`default_nettype wire

// ---- rtl/fpe_array.sv ----
// nonvolatile byte array with erase sweep and bit-clearing program
`default_nettype none
module fpe_array #(
  parameter int unsigned AW = 16
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // sequencer side
  fpe_arr_if.arr    a
);
  if (AW != fpe_pkg::ARR_AW) begin : g_chk
    $error("array width must be 16");
  end

  typedef struct packed {
    fpe_pkg::fpe_sweep_t mode;
    logic [15:0]         addr;
    logic [fpe_pkg::PAGE_BITS:0] cnt;
  } fpe_arr_st_t;

  fpe_arr_st_t st_q, st_d;
  logic [7:0]  mem [0:(1<<AW)-1];
  logic        erase_we;
  logic [15:0] last;

  // ==========================================================================
  // sweep control
  always_comb begin
    st_d = st_q;
    // page sweep byte count
    st_d.cnt = (st_q.mode == fpe_pkg::SW_PAGE) ?
               st_q.cnt + {{fpe_pkg::PAGE_BITS{1'b0}}, 1'b1} : '0;
    last = (st_q.mode == fpe_pkg::SW_MASS) ? fpe_pkg::MEM_TOP : {st_q.addr[15:9], 9'h1FF};
    unique case (st_q.mode)
      fpe_pkg::SW_IDLE: begin
        if (a.erase_stb) begin
          st_d.mode = a.erase_mass ? fpe_pkg::SW_MASS : fpe_pkg::SW_PAGE;
          st_d.addr = a.erase_mass ? 16'h0000 : {a.erase_page, 9'h000};
        end
      end
      fpe_pkg::SW_PAGE, fpe_pkg::SW_MASS: begin
        if (st_q.addr == last) begin
          st_d.mode = fpe_pkg::SW_IDLE;
        end else begin
          st_d.addr = st_q.addr + 16'h0001;
        end
      end
      default: st_d.mode = fpe_pkg::SW_IDLE;
    endcase
  end

  assign erase_we = (st_q.mode == fpe_pkg::SW_MASS) ||
                    ((st_q.mode == fpe_pkg::SW_PAGE) && (st_q.addr < fpe_pkg::KEEP_LO));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{fpe_pkg::SW_IDLE, 16'h0000, '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // storage
  always_ff @(posedge pclk) begin
    if (erase_we) begin
      mem[st_q.addr] <= fpe_pkg::ERASED_BYTE;
    end else if (a.prog_stb) begin
      mem[a.prog_addr] <= mem[a.prog_addr] & a.prog_data;
    end
  end

  assign a.rd_data   = mem[a.rd_addr];
  assign a.busy      = (st_q.mode != fpe_pkg::SW_IDLE);
  assign a.clock_opt = {mem[fpe_pkg::CLK_OPT_ADDR][fpe_pkg::OSC_HI_BIT],
                        mem[fpe_pkg::CLK_OPT_ADDR][fpe_pkg::OSC_LO_BIT]};

  // ==========================================================================
  // checks
  a_vector_kept: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.mode == fpe_pkg::SW_PAGE) && (st_q.addr >= fpe_pkg::KEEP_LO) |-> !erase_we)
    else $error("page erase touched vector area");
  a_page_align: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.mode == fpe_pkg::SW_PAGE) |->
      (st_q.addr[8:0] == st_q.cnt[8:0]) && !st_q.cnt[fpe_pkg::PAGE_BITS])
    else $error("page erase not 512 aligned bytes");
  a_page_len: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.mode == fpe_pkg::SW_PAGE) |=>
      (a.busy == ($past(st_q.cnt) != {1'b0, {fpe_pkg::PAGE_BITS{1'b1}}})))
    else $error("page erase length not 512 cycles");
endmodule : fpe_array
`default_nettype wire

// ---- rtl/fpe_top.sv ----
// apb sequencer for nvm program, erase and block protection
// Function
// - high voltage needs program or erase armed
// - mass bit picks whole or page erase
// - program and erase never both set
// - erased bit reads one, programmed zero
// - page erase covers 512 aligned bytes
// - page erase never clears vector area
// - erase-armed array write latches target page
// - program rows are 64 aligned bytes
// - program mode latches and programs writes
// - protected target refuses high voltage
// - protect start from upper seven bits
// - protection runs up to top address
// - all ones disables block protection
// - low codes all, top codes option area
// - option byte and vectors protected except from mass erase
// - option byte gives oscillator select bits
`default_nettype none
module fpe_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [18:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // charge pump and oscillator option
  output logic             high_voltage_enable,
  output logic             osc_select_hi,
  output logic             osc_select_lo
);
  typedef struct packed {
    fpe_pkg::fpe_ctl_t ctl;
    logic [7:0]        block_protect_start;
    logic              tgt_valid;
    logic [15:0]       tgt;
    logic              refused;
    logic [31:0]       prdata;
    logic [1:0]        osc;
  } fpe_top_st_t;

  fpe_top_st_t       st_q, st_d;
  fpe_arr_if         arr ();
  fpe_pkg::fpe_ctl_t wr_ctl;
  logic [15:0]       arr_addr;
  logic              hit_array, hit_ctl, hit_prot, hit_stat, hit_any;
  logic              acc_wr, arr_wr, ctl_wr;
  logic              tgt_hit, byte_hit, blocked, hv_ok, hv_go;
  logic [31:0]       rd_mux;

  // ==========================================================================
  // address decode
  assign arr_addr  = paddr[17:2];
  assign hit_array = paddr[fpe_pkg::ARRAY_SEL] && (paddr[1:0] == 2'b00);
  assign hit_ctl   = (paddr == fpe_pkg::ADDR_CONTROL);
  assign hit_prot  = (paddr == fpe_pkg::ADDR_PROTECT);
  assign hit_stat  = (paddr == fpe_pkg::ADDR_STATUS);
  assign hit_any   = hit_array || hit_ctl || hit_prot || hit_stat;
  assign acc_wr    = psel && penable && pwrite && pstrb[0] && hit_any;
  assign arr_wr    = acc_wr && hit_array;
  assign ctl_wr    = acc_wr && hit_ctl;
  assign wr_ctl    = fpe_pkg::fpe_ctl_t'(pwdata[3:0]);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !hit_any;

  // ==========================================================================
  // protection
  fpe_prot u_prot_tgt (
    .protect_start_bits (st_q.block_protect_start),
    .addr               (st_q.tgt),
    .start (),
    .hit   (tgt_hit)
  );

  fpe_prot u_prot_byte (
    .protect_start_bits (st_q.block_protect_start),
    .addr               (arr_addr),
    .start (),
    .hit   (byte_hit)
  );

  // mass erase needs block protection off (all ones); other modes check the target
  assign blocked = (st_q.ctl.erase && st_q.ctl.mass) ?
                   (st_q.block_protect_start != fpe_pkg::PROT_NONE) :
                   tgt_hit;
  assign hv_ok   = (st_q.ctl.program_select || st_q.ctl.erase) && st_q.tgt_valid &&
                   !blocked && !arr.busy;
  assign hv_go   = ctl_wr && wr_ctl.high_voltage_enable && !st_q.ctl.high_voltage_enable &&
                   hv_ok;

  // ==========================================================================
  // array port
  assign arr.rd_addr    = arr_addr;
  assign arr.prog_stb   = arr_wr && st_q.ctl.program_select && st_q.ctl.high_voltage_enable &&
                          (arr_addr[15:6] == st_q.tgt[15:6]) && !byte_hit;
  assign arr.prog_addr  = arr_addr;
  assign arr.prog_data  = pwdata[7:0];
  assign arr.erase_stb  = hv_go && st_q.ctl.erase;
  assign arr.erase_mass = st_q.ctl.mass;
  assign arr.erase_page = st_q.tgt[15:9];

  fpe_array #(
    .AW (fpe_pkg::ARR_AW)
  ) u_array (
    .pclk    (pclk),
    .presetn (presetn),
    .a       (arr)
  );

  // ==========================================================================
  // read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_array) begin
      rd_mux = {24'h00_0000, arr.rd_data};
    end else if (hit_ctl) begin
      rd_mux = {28'h000_0000, st_q.ctl};
    end else if (hit_prot) begin
      rd_mux = {24'h00_0000, st_q.block_protect_start};
    end else if (hit_stat) begin
      rd_mux = {29'h0000_0000, st_q.refused, arr.busy, st_q.tgt_valid};
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    st_d     = st_q;
    st_d.osc = arr.clock_opt;
    if (psel && !penable && !pwrite) begin
      st_d.prdata = rd_mux;
    end
    if (acc_wr && hit_prot) begin
      st_d.block_protect_start = pwdata[7:0];
    end
    if (acc_wr && hit_stat && pwdata[fpe_pkg::ST_REFUSED]) begin
      st_d.refused = 1'b0;
    end
    if (ctl_wr) begin
      st_d.ctl.mass = wr_ctl.mass;
      if (!(wr_ctl.program_select && wr_ctl.erase)) begin
        st_d.ctl.program_select = wr_ctl.program_select;
        st_d.ctl.erase          = wr_ctl.erase;
      end
      if (!wr_ctl.high_voltage_enable) begin
        st_d.ctl.high_voltage_enable = 1'b0;
      end else if (hv_go) begin
        st_d.ctl.high_voltage_enable = 1'b1;
      end else if (!st_q.ctl.high_voltage_enable) begin
        st_d.refused = 1'b1;
      end
    end
    if (arr_wr && (st_q.ctl.program_select || st_q.ctl.erase) &&
        !st_q.ctl.high_voltage_enable) begin
      st_d.tgt_valid = 1'b1;
      st_d.tgt       = arr_addr;
    end
    if (!st_d.ctl.program_select && !st_d.ctl.erase) begin
      st_d.tgt_valid = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{fpe_pkg::CTL_RESET, fpe_pkg::PROT_RESET, 1'b0, 16'h0000, 1'b0,
                32'h0000_0000, 2'b11};
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata              = st_q.prdata;
  assign high_voltage_enable = st_q.ctl.high_voltage_enable;
  assign osc_select_hi       = st_q.osc[1];
  assign osc_select_lo       = st_q.osc[0];

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_excl_modes: assert property (
    !(st_q.ctl.program_select && st_q.ctl.erase))
    else $error("program and erase both set");
  a_hv_armed: assert property (
    $rose(st_q.ctl.high_voltage_enable) |->
      $past(st_q.ctl.program_select || st_q.ctl.erase) && $past(st_q.tgt_valid))
    else $error("high voltage set while not armed");
  a_hv_protect: assert property (
    ctl_wr && wr_ctl.high_voltage_enable && !st_q.ctl.high_voltage_enable && blocked
      |=> !st_q.ctl.high_voltage_enable && st_q.refused)
    else $error("high voltage set on protected target");
  a_mass_kick: assert property (
    arr.erase_stb && arr.erase_mass |=> arr.busy [*8])
    else $error("mass erase did not start");
  a_tgt_latch: assert property (
    arr_wr && st_q.ctl.erase && !st_q.ctl.high_voltage_enable
      |=> st_q.tgt_valid && (st_q.tgt == $past(arr_addr)))
    else $error("erase target not latched");
  a_row_only: assert property (
    arr.prog_stb |-> (arr.prog_addr[15:6] == st_q.tgt[15:6]) && st_q.ctl.high_voltage_enable)
    else $error("program outside latched row");
  a_keep_top: assert property (
    arr_wr && (arr_addr >= fpe_pkg::KEEP_LO) |-> !arr.prog_stb)
    else $error("option or vector byte programmed");
  a_prot_none: assert property (
    (st_q.block_protect_start == fpe_pkg::PROT_NONE) &&
    (st_q.tgt < fpe_pkg::KEEP_LO) |-> !tgt_hit)
    else $error("protection with all ones value");
  a_prot_all: assert property (
    (st_q.block_protect_start <= fpe_pkg::PROT_ALL_MAX) |-> tgt_hit)
    else $error("low protect code left a hole");
  a_read_data: assert property (
    psel && !penable && !pwrite && hit_ctl |=> prdata[3:0] == $past(st_q.ctl))
    else $error("control readback wrong");

  // ==========================================================================
  // mode and high voltage checks
  a_hv_drop: assert property (
    ctl_wr && !wr_ctl.high_voltage_enable |=> !st_q.ctl.high_voltage_enable)
    else $error("high voltage kept after clear");
  a_sweep_hv: assert property (
    $rose(arr.busy) |-> st_q.ctl.high_voltage_enable)
    else $error("erase sweep without high voltage");
  a_both_kept: assert property (
    ctl_wr && wr_ctl.program_select && wr_ctl.erase
      |=> (st_q.ctl.program_select == $past(st_q.ctl.program_select)) &&
          (st_q.ctl.erase == $past(st_q.ctl.erase)))
    else $error("double mode write changed mode bits");
  a_page_kick: assert property (
    arr.erase_stb && !arr.erase_mass |=> arr.busy [*8])
    else $error("page erase did not start");
  a_erase_hv: assert property (
    arr.erase_stb |=> st_q.ctl.high_voltage_enable)
    else $error("erase started without high voltage");
  a_prog_mode: assert property (
    arr.prog_stb |-> st_q.ctl.program_select && !st_q.ctl.erase)
    else $error("program strobe outside program mode");
  a_prog_latch: assert property (
    arr_wr && st_q.ctl.program_select && !st_q.ctl.high_voltage_enable
      |=> st_q.tgt_valid && (st_q.tgt == $past(arr_addr)))
    else $error("program row not latched");
  a_tgt_clear: assert property (
    !st_q.ctl.program_select && !st_q.ctl.erase |-> !st_q.tgt_valid)
    else $error("target kept with no mode armed");
  a_tgt_hold: assert property (
    st_q.ctl.high_voltage_enable |=> $stable(st_q.tgt))
    else $error("target moved under high voltage");
  a_erase_no_prog: assert property (
    arr_wr && st_q.ctl.erase |-> !arr.prog_stb)
    else $error("erase mode array write programmed");
  a_refused_kept: assert property (
    st_q.refused && !(acc_wr && hit_stat && pwdata[fpe_pkg::ST_REFUSED])
      |=> st_q.refused)
    else $error("refused flag lost");

  // ==========================================================================
  // protect decode checks
  a_prot_write: assert property (
    acc_wr && hit_prot |=> st_q.block_protect_start == $past(arr.prog_data))
    else $error("protect register write lost");
  a_prot_start: assert property (
    (st_q.block_protect_start > fpe_pkg::PROT_ALL_MAX) &&
    (st_q.block_protect_start < fpe_pkg::PROT_TOP_MIN) && (st_q.tgt < fpe_pkg::KEEP_LO)
      |-> tgt_hit == (st_q.tgt[15:9] >= st_q.block_protect_start[7:1]))
    else $error("protect start not page aligned");
  a_prot_top: assert property (
    (st_q.block_protect_start >= fpe_pkg::PROT_TOP_MIN) &&
    (st_q.block_protect_start != fpe_pkg::PROT_NONE)
      |-> tgt_hit == (st_q.tgt >= fpe_pkg::KEEP_LO))
    else $error("top protect codes wrong range");
  a_prot_vec: assert property (
    (st_q.tgt >= fpe_pkg::KEEP_LO) |-> tgt_hit)
    else $error("option or vector target unprotected");

  c_page_erase: cover property (arr.erase_stb && !arr.erase_mass);
  c_mass_erase: cover property (arr.erase_stb && arr.erase_mass);
  c_prog_byte:  cover property (arr.prog_stb);
  c_refused:    cover property ($rose(st_q.refused));
  c_row_last:   cover property (arr.prog_stb && (arr.prog_addr[5:0] == 6'h3F));
endmodule : fpe_top
`default_nettype wire

// ---- dv/fpe_cpu.sv ----
// cpu model that runs the nvm sequences from ram over apb
`default_nettype none
module fpe_cpu (
  // clock
  input  wire logic        pclk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [18:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 19'h0;
    pwdata  = 32'h0;
    pstrb   = 4'hF;
  end
  function automatic logic [18:0] arr(input logic [15:0] x);
    return {1'b1, x, 2'b00};
  endfunction : arr
  // ==========================================================================
  // bus cycles
  task automatic xfer(input logic w, input logic [18:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [18:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, {24'h0, d}, 4'hF, r);
  endtask : wr
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  // ==========================================================================
  // sequences
  // erase steps kept in order
  task automatic erase(input logic [15:0] a, input logic mass, output logic [31:0] st);
    logic [7:0] c;
    c = mass ? 8'h06 : 8'h02;
    wr(fpe_pkg::ADDR_CONTROL, c);
    wr(arr(a), 8'h00);
    idle(5);
    wr(fpe_pkg::ADDR_CONTROL, c | 8'h08);
    do xfer(1'b0, fpe_pkg::ADDR_STATUS, 32'h0, 4'hF, st);
    while (st[fpe_pkg::ST_BUSY] !== 1'b0);
    wr(fpe_pkg::ADDR_CONTROL, 8'h08);
    idle(5);
    wr(fpe_pkg::ADDR_CONTROL, 8'h00);
    idle(2);
  endtask : erase
  task automatic prog_open(input logic [15:0] a);
    wr(fpe_pkg::ADDR_CONTROL, 8'h01);
    wr(arr(a), 8'hFF);
    idle(5);
    wr(fpe_pkg::ADDR_CONTROL, 8'h09);
    idle(5);
  endtask : prog_open
  task automatic prog_close();
    wr(fpe_pkg::ADDR_CONTROL, 8'h08);
    idle(5);
    wr(fpe_pkg::ADDR_CONTROL, 8'h00);
    idle(2);
  endtask : prog_close
endmodule : fpe_cpu
`default_nettype wire

// ---- dv/tb_flash_program_erase_protect.sv ----
// self-checking bench for the nvm program, erase and protect block
`default_nettype none
module tb_flash_program_erase_protect;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [18:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hv;
  logic        osc_hi;
  logic        osc_lo;
  logic [32:0] exp_q[$];
  int          num_errors;
  int          comparisons;
  logic [31:0] seed;
  logic [31:0] st;
  logic [7:0]  d[4];
  logic [7:0]  t_prot[9] = '{8'h09, 8'h01, 8'h0A, 8'h0B, 8'hFB, 8'hFA, 8'hFC, 8'hFF, 8'hFF};
  logic [15:0] t_adr[9] = '{16'h1000, 16'h0000, 16'h09C0, 16'h0A00, 16'hF9C0, 16'hFA00,
                            16'hFFCF, 16'hFFD0, 16'h0000};
  logic        t_ok[9]  = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  fpe_top fpe_top_inst (
    .pclk                (pclk),
    .presetn             (presetn),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .pstrb               (pstrb),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .high_voltage_enable (hv),
    .osc_select_hi       (osc_hi),
    .osc_select_lo       (osc_lo)
  );
  fpe_cpu fpe_cpu_inst (
    .pclk    (pclk),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready)
  );
  // ==========================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [18:0] a, input logic [31:0] e, input logic err = 1'b0);
    logic [31:0] r;
    exp_q.push_back({err, e});
    fpe_cpu_inst.xfer(1'b0, a, 32'h0, 4'hF, r);
  endtask : rd
  task automatic results();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // ==========================================================================
  // clock, monitor, watchdog
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready && exp_q.size() > 0) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    results();
  end
  // ==========================================================================
  // main sequence
  initial begin
    num_errors  = 0;
    comparisons = 0;
    seed        = 32'hb2e2;
    presetn     = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(fpe_pkg::ADDR_PROTECT, 32'h0);
    rd(fpe_pkg::ADDR_CONTROL, 32'h0);
    rd(19'h3F830, 32'h0, 1'b1);
    fpe_cpu_inst.xfer(1'b1, fpe_pkg::ADDR_PROTECT, 32'hFF, 4'hE, st);
    rd(fpe_pkg::ADDR_PROTECT, 32'h0);
    fpe_cpu_inst.wr(fpe_pkg::ADDR_CONTROL, 8'h08);
    rd(fpe_pkg::ADDR_CONTROL, 32'h0);
    rd(fpe_pkg::ADDR_STATUS, 32'h4);
    fpe_cpu_inst.wr(fpe_pkg::ADDR_STATUS, 8'h04);
    fpe_cpu_inst.wr(fpe_pkg::ADDR_CONTROL, 8'h03);
    rd(fpe_pkg::ADDR_CONTROL, 32'h0);
    fpe_cpu_inst.erase(16'h1000, 1'b1, st);
    chk({1'b0, st}, 33'h5);
    fpe_cpu_inst.wr(fpe_pkg::ADDR_STATUS, 8'h04);
    // protect start decode over a table of codes and targets
    for (int i = 0; i < 9; i++) begin
      fpe_cpu_inst.wr(fpe_pkg::ADDR_PROTECT, t_prot[i]);
      fpe_cpu_inst.prog_open(t_adr[i]);
      rd(fpe_pkg::ADDR_CONTROL, t_ok[i] ? 32'h9 : 32'h1);
      rd(fpe_pkg::ADDR_STATUS, t_ok[i] ? 32'h1 : 32'h5);
      chk({32'h0, hv}, {32'h0, t_ok[i]});
      fpe_cpu_inst.wr(fpe_pkg::ADDR_CONTROL, 8'h00);
      fpe_cpu_inst.wr(fpe_pkg::ADDR_STATUS, 8'h04);
    end
    fpe_cpu_inst.erase(16'h0000, 1'b1, st);
    chk({1'b0, st}, 33'h1);
    rd(fpe_cpu_inst.arr(16'h0000), 32'hFF);
    rd(fpe_cpu_inst.arr(16'hFFCF), 32'hFF);
    chk({31'h0, osc_hi, osc_lo}, 33'h3);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      d[i] = seed[7:0];
    end
    fpe_cpu_inst.prog_open(16'h1000);
    fpe_cpu_inst.wr(fpe_cpu_inst.arr(16'h1000), d[0]);
    fpe_cpu_inst.wr(fpe_cpu_inst.arr(16'h103F), d[1]);
    fpe_cpu_inst.wr(fpe_cpu_inst.arr(16'h1040), d[2]);
    fpe_cpu_inst.prog_close();
    fpe_cpu_inst.prog_open(16'h1200);
    fpe_cpu_inst.wr(fpe_cpu_inst.arr(16'h1200), d[3]);
    fpe_cpu_inst.prog_close();
    rd(fpe_cpu_inst.arr(16'h1000), {24'h0, d[0]});
    rd(fpe_cpu_inst.arr(16'h103F), {24'h0, d[1]});
    rd(fpe_cpu_inst.arr(16'h1040), 32'hFF);
    fpe_cpu_inst.erase(16'h1010, 1'b0, st);
    chk({1'b0, st}, 33'h1);
    rd(fpe_cpu_inst.arr(16'h1000), 32'hFF);
    rd(fpe_cpu_inst.arr(16'h103F), 32'hFF);
    rd(fpe_cpu_inst.arr(16'h1200), {24'h0, d[3]});
    chk({1'b0, 32'(exp_q.size())}, 33'h0);
    results();
  end
endmodule : tb_flash_program_erase_protect
`default_nettype wire
